// file: testbench.sv
// self-checking bench: apb master tasks plus a remote transceiver
// assumes one fixed apb wait state and a system-clock timer source
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  localparam logic [7:0] RLD = 8'hf8;
  localparam int BIT = 2 * (256 - 8'hf8);
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic rxd, txd, ext_osc_clk, timer_ext, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] gn;
  int failures, check_count, cyc;
  uart_timer_baud dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
    .ext_osc_clk(ext_osc_clk), .timer_external_input(timer_ext), .irq(irq));
  uart_remote #(.BIT(BIT)) far (.pclk(pclk), .line_in(txd), .line_out(rxd),
    .got(), .got_n());
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // unused oscillator clock still toggles so its sampler sees activity; timer pin held low
  initial begin
    ext_osc_clk = 1'b0;
    forever #23 ext_osc_clk = ~ext_osc_clk;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    `CHK(pready, 1'b1)
    `CHK(pslverr, 1'b0)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd & m, e)
  endtask : rdc
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    `CHK(irq, 1'b1)
  endtask : wait_irq
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, timer_ext} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(uart_pkg::ADDR_CTRL, 32'hff, 32'h0);
    rdc(uart_pkg::ADDR_RELOAD, 32'hff, 32'h0);
    // unmapped place answers with an error and zero data
    @(posedge pclk);
    {psel, paddr, pwrite} <= {1'b1, 8'h1c, 1'b0};
    @(posedge pclk);
    penable <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK({pslverr, prdata}, 33'h100000000)
    {psel, penable} <= 2'b00;
    $display("test reset and map done");
    bus(1'b1, uart_pkg::ADDR_RELOAD, {24'h0, RLD});
    bus(1'b1, uart_pkg::ADDR_TMR, 32'h1);
    bus(1'b1, uart_pkg::ADDR_MASK, 32'h3);
    bus(1'b1, uart_pkg::ADDR_CTRL, 32'h10);
    rdc(uart_pkg::ADDR_RELOAD, 32'hff, {24'h0, RLD});
    gn = far.got_n;
    bus(1'b1, uart_pkg::ADDR_DATA, 32'ha5);
    wait_irq();
    rdc(uart_pkg::ADDR_STAT, 32'h3, 32'h2);
    repeat (12 * BIT) @(posedge pclk);
    `CHK(far.got_n, gn + 8'h01)
    `CHK(far.got, 8'ha5)
    rdc(uart_pkg::ADDR_STAT, 32'h3, 32'h2);
    rdc(uart_pkg::ADDR_DATA, 32'hff, 32'h0);
    bus(1'b1, uart_pkg::ADDR_STAT, 32'h2);
    rdc(uart_pkg::ADDR_STAT, 32'h3, 32'h0);
    `CHK(irq, 1'b0)
    $display("test transmit done");
    far.send(8'h3c, 1'b0, 1'b0);
    wait_irq();
    rdc(uart_pkg::ADDR_STAT, 32'h3, 32'h1);
    far.send(8'h55, 1'b0, 1'b0);
    repeat (2 * BIT) @(posedge pclk);
    rdc(uart_pkg::ADDR_DATA, 32'hff, 32'h3c);
    bus(1'b1, uart_pkg::ADDR_STAT, 32'h1);
    $display("test receive done");
    bus(1'b1, uart_pkg::ADDR_CTRL, 32'hb0);
    far.send(8'h77, 1'b1, 1'b0);
    repeat (2 * BIT) @(posedge pclk);
    rdc(uart_pkg::ADDR_STAT, 32'h3, 32'h0);
    far.send(8'h99, 1'b1, 1'b1);
    wait_irq();
    rdc(uart_pkg::ADDR_DATA, 32'hff, 32'h99);
    rdc(uart_pkg::ADDR_CTRL, 32'h4, 32'h4);
    $display("test ninth bit filter done");
    give_verdict();
  end
endmodule : testbench

// file: uart_pkg.sv
// constants and types for the timer-paced serial port
// assumes a single 100 MHz pclk domain and an APB register bus
package uart_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_TMR = 8'h08;
  localparam logic [7:0] ADDR_RELOAD = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  // serial_control_reg fields
  localparam int CTRL_MODE9 = 7;
  localparam int CTRL_MCE = 5;
  localparam int CTRL_REN = 4;
  localparam int CTRL_TB8 = 3;
  localparam int CTRL_RB8 = 2;
  localparam logic [7:0] CTRL_WMASK = 8'hbc;
  // status and mask fields
  localparam int STAT_RI = 0;
  localparam int STAT_TI = 1;
  // timer control fields
  localparam int TMR_RUN = 0;
  localparam int TMR_SEL_LO = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hff;
  localparam logic [5:0] PRE_LAST = 6'h2f;
  localparam logic [3:0] PRE_QUAD_END = 4'h3;
  localparam logic [5:0] PRE_TWELVE = 6'h0c;
  localparam logic [5:0] PRE_TWELVE_END = 6'h0b;
  localparam logic [2:0] XOSC_LAST = 3'h7;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  typedef enum logic [2:0] {
    SEL_SYS = 3'h0, SEL_DIV4 = 3'h1, SEL_DIV12 = 3'h2,
    SEL_DIV48 = 3'h3, SEL_XOSC8 = 3'h4, SEL_EXT = 3'h5
  } clk_sel_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_SHIFT = 2'b11, TX_STOP = 2'b10
  } tx_state_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11, RX_STOP = 2'b10
  } rx_state_t;
  typedef struct packed {
    logic rx_s1, rx_s2, rx_s3;
    logic xo_s1, xo_s2, xo_s3;
    logic ex_s1, ex_s2, ex_s3;
    logic [5:0] pre;
    logic [2:0] xdiv;
    logic [7:0] ctrl;
    logic [3:0] tmr;
    logic [7:0] reload;
    logic [7:0] tl;
    logic [7:0] rx_tl;
    logic tx_div, rx_div;
    logic [1:0] stat, mask;
    tx_state_t tx_st;
    logic [8:0] tx_sh;
    logic [3:0] tx_cnt;
    logic txd;
    rx_state_t rx_st;
    logic [8:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [7:0] rx_buf;
    logic [31:0] prdata;
    logic pready, pslverr, irq;
  } state_t;
endpackage : uart_pkg

// file: uart_remote.sv
// remote serial transceiver facing the port's txd and rxd pins
// assumes BIT pclk cycles per bit on both sides; line idles high
`timescale 1ns/100ps
module uart_remote #(parameter int BIT = 16) (
  input wire logic pclk,
  input wire logic line_in,
  output logic line_out,
  output logic [7:0] got,
  output logic [7:0] got_n
);
  logic [7:0] sh;
  initial begin
    line_out = 1'b1;
    got = 8'h00;
    got_n = 8'h00;
  end
  // start, data lsb first, ninth in 9-bit frames, then stop
  task automatic send(input logic [7:0] d, input logic nine, input logic b9);
    logic [10:0] f;
    f = nine ? {1'b1, b9, d, 1'b0} : {2'b11, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge pclk);
      line_out <= f[i];
      repeat (BIT - 1) @(posedge pclk);
    end
  endtask : send
  // samples mid-bit; a frame with a low stop is dropped
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge pclk);
      sh[i] = line_in;
    end
    repeat (BIT) @(posedge pclk);
    if (line_in === 1'b1) begin
      got <= sh;
      got_n <= got_n + 8'h01;
    end
  end
endmodule : uart_remote

// file: uart_timer_baud.sv
// serial port with 8/9-bit frames, buffered receive and a timer baud generator
// assumes an APB master on pclk; rxd and the two timer clock pins are asynchronous
//
// Functional notes
// - only the 8-bit and 9-bit variable-rate frame modes exist
// - received byte is buffered so the next frame can arrive meanwhile
// - writing the data location loads the transmitter and starts sending; a write while the transmitter is not idle is ignored
// - reading the data location returns the receive buffer; transmitter unreadable
// - interrupt requested when an enabled done flag becomes set
// - done flags stay set until software clears them
// - bit rate comes from overflows of an 8-bit auto-reload timer
// - transmit paced by the visible count, receive by a hidden copy
// - both overflow streams are halved to form the bit rates
// - receive copy runs with the timer and reloads from the same byte
// - a start edge on the receive line forces the copy to reload
// - timer counts one of six clocks: system, /4, /12, /48, osc/8, pin
// - external oscillator may pace the timer while system clock stays internal
// - 8-bit frame: start, eight data bits lsb first, stop
// - 9-bit frame adds a ninth bit; received ninth is kept, stop ignored
// - transmit done flag sets at the start of the stop bit
// - receive loads only if flag clear and, when filtering, ninth or stop is one
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module uart_timer_baud (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  input wire logic ext_osc_clk,
  input wire logic timer_external_input,
  output logic irq
);
  uart_pkg::state_t st;
  uart_pkg::state_t next_st;
  logic run;
  logic pre_tick;
  logic tick;
  logic tx_ovf;
  logic rx_ovf;
  logic tx_bit;
  logic rx_samp;
  logic start_det;
  logic wr_go;
  logic rd_go;
  logic [3:0] nbits;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == uart_pkg::ADDR_CTRL) || (a == uart_pkg::ADDR_DATA) ||
             (a == uart_pkg::ADDR_TMR) || (a == uart_pkg::ADDR_RELOAD) ||
             (a == uart_pkg::ADDR_STAT) || (a == uart_pkg::ADDR_MASK);
  endfunction : mapped

  // timer clock selection; slower clocks are one-cycle enables
  always_comb begin
    case (uart_pkg::clk_sel_t'(st.tmr[uart_pkg::TMR_SEL_LO +: 3]))
      uart_pkg::SEL_SYS: pre_tick = 1'b1;
      uart_pkg::SEL_DIV4: pre_tick = (st.pre[1:0] == uart_pkg::PRE_QUAD_END[1:0]);
      uart_pkg::SEL_DIV12: pre_tick = ((st.pre % uart_pkg::PRE_TWELVE) ==
                                       uart_pkg::PRE_TWELVE_END);
      uart_pkg::SEL_DIV48: pre_tick = (st.pre == uart_pkg::PRE_LAST);
      // oscillator edges are counted here, system clock untouched
      uart_pkg::SEL_XOSC8: pre_tick = st.xo_s2 && !st.xo_s3 &&
                                      (st.xdiv == uart_pkg::XOSC_LAST);
      uart_pkg::SEL_EXT: pre_tick = st.ex_s2 && !st.ex_s3;
      default: pre_tick = 1'b0;
    endcase
  end

  assign run = st.tmr[uart_pkg::TMR_RUN];
  assign tick = run && pre_tick;
  assign tx_ovf = tick && (st.tl == uart_pkg::COUNT_TOP);
  assign rx_ovf = tick && (st.rx_tl == uart_pkg::COUNT_TOP);
  assign tx_bit = tx_ovf && st.tx_div;
  // first halved overflow after a start reload lands mid-bit
  assign rx_samp = rx_ovf && !st.rx_div;
  assign start_det = run && st.ctrl[uart_pkg::CTRL_REN] && (st.rx_st == uart_pkg::RX_IDLE) &&
                     st.rx_s3 && !st.rx_s2;
  assign wr_go = psel && penable && st.pready && pwrite;
  assign rd_go = psel && penable && !st.pready && !pwrite;
  assign nbits = st.ctrl[uart_pkg::CTRL_MODE9] ? uart_pkg::BITS_NINE :
                 uart_pkg::BITS_EIGHT;

  always_comb begin
    logic [1:0] set_f;
    logic [1:0] clr_f;
    logic ninth;
    set_f = 2'h0;
    clr_f = 2'h0;
    ninth = 1'b0;
    next_st = st;
    // synchronisers: first stage feeds only the second
    next_st.rx_s1 = rxd;
    next_st.rx_s2 = st.rx_s1;
    next_st.rx_s3 = st.rx_s2;
    next_st.xo_s1 = ext_osc_clk;
    next_st.xo_s2 = st.xo_s1;
    next_st.xo_s3 = st.xo_s2;
    next_st.ex_s1 = timer_external_input;
    next_st.ex_s2 = st.ex_s1;
    next_st.ex_s3 = st.ex_s2;
    next_st.pre = (st.pre == uart_pkg::PRE_LAST) ? 6'h00 : st.pre + 6'h01;
    if (st.xo_s2 && !st.xo_s3) begin
      next_st.xdiv = st.xdiv + 3'h1;
    end
    // visible count and hidden receive copy share the reload byte
    if (tick) begin
      next_st.tl = tx_ovf ? st.reload : st.tl + 8'h01;
      next_st.rx_tl = rx_ovf ? st.reload : st.rx_tl + 8'h01;
    end
    if (tx_ovf) begin
      next_st.tx_div = !st.tx_div;
    end
    if (rx_ovf) begin
      next_st.rx_div = !st.rx_div;
    end
    if (start_det) begin
      next_st.rx_tl = st.reload;
      next_st.rx_div = 1'b0;
      next_st.rx_st = uart_pkg::RX_START;
    end
    // transmitter
    case (st.tx_st)
      uart_pkg::TX_IDLE: begin
        if (wr_go && paddr == uart_pkg::ADDR_DATA) begin
          next_st.tx_sh = {st.ctrl[uart_pkg::CTRL_TB8], pwdata[7:0]};
          next_st.tx_st = uart_pkg::TX_WAIT;
        end
      end
      uart_pkg::TX_WAIT: begin
        if (tx_bit) begin
          next_st.txd = 1'b0;
          next_st.tx_cnt = 4'h0;
          next_st.tx_st = uart_pkg::TX_SHIFT;
        end
      end
      uart_pkg::TX_SHIFT: begin
        if (tx_bit) begin
          if (st.tx_cnt == nbits) begin
            next_st.txd = 1'b1;
            next_st.tx_st = uart_pkg::TX_STOP;
            set_f[uart_pkg::STAT_TI] = 1'b1;
          end else begin
            next_st.txd = st.tx_sh[0];
            next_st.tx_sh = {1'b0, st.tx_sh[8:1]};
            next_st.tx_cnt = st.tx_cnt + 4'h1;
          end
        end
      end
      uart_pkg::TX_STOP: begin
        if (tx_bit) begin
          next_st.tx_st = uart_pkg::TX_IDLE;
        end
      end
      default: next_st.tx_st = uart_pkg::TX_IDLE;
    endcase
    // receiver; shift register is separate from the buffer
    case (st.rx_st)
      uart_pkg::RX_IDLE: ;
      uart_pkg::RX_START: begin
        if (rx_samp) begin
          // a glitch shorter than half a bit is dropped
          next_st.rx_st = st.rx_s2 ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
          next_st.rx_cnt = 4'h0;
        end
      end
      uart_pkg::RX_DATA: begin
        if (rx_samp) begin
          next_st.rx_sh = {st.rx_s2, st.rx_sh[8:1]};
          next_st.rx_cnt = st.rx_cnt + 4'h1;
          if (st.rx_cnt == nbits - 4'h1) begin
            next_st.rx_st = uart_pkg::RX_STOP;
          end
        end
      end
      uart_pkg::RX_STOP: begin
        if (rx_samp) begin
          ninth = st.ctrl[uart_pkg::CTRL_MODE9] ? st.rx_sh[8] : st.rx_s2;
          if (!st.stat[uart_pkg::STAT_RI] &&
              (!st.ctrl[uart_pkg::CTRL_MCE] || ninth)) begin
            next_st.rx_buf = st.ctrl[uart_pkg::CTRL_MODE9] ? st.rx_sh[7:0] :
                             st.rx_sh[8:1];
            set_f[uart_pkg::STAT_RI] = 1'b1;
          end
          next_st.rx_st = uart_pkg::RX_IDLE;
        end
      end
      default: next_st.rx_st = uart_pkg::RX_IDLE;
    endcase
    // register writes take effect on the completing edge
    if (wr_go) begin
      if (paddr == uart_pkg::ADDR_CTRL) begin
        next_st.ctrl = pwdata[7:0] & uart_pkg::CTRL_WMASK;
      end else if (paddr == uart_pkg::ADDR_TMR) begin
        next_st.tmr = pwdata[3:0];
      end else if (paddr == uart_pkg::ADDR_RELOAD) begin
        next_st.reload = pwdata[7:0];
      end else if (paddr == uart_pkg::ADDR_STAT) begin
        clr_f = pwdata[1:0];
      end else if (paddr == uart_pkg::ADDR_MASK) begin
        next_st.mask = pwdata[1:0];
      end
    end
    if (set_f[uart_pkg::STAT_RI]) begin
      next_st.ctrl[uart_pkg::CTRL_RB8] = ninth;
    end
    // set beats a simultaneous clear so no event is lost
    next_st.stat = (st.stat & ~clr_f) | set_f;
    next_st.irq = |(next_st.stat & next_st.mask);
    // one wait state: data and pready come from flops
    next_st.pready = psel && penable && !st.pready;
    next_st.pslverr = psel && penable && !st.pready && !mapped(paddr);
    next_st.prdata = 32'h0000_0000;
    if (rd_go) begin
      if (paddr == uart_pkg::ADDR_CTRL) begin
        next_st.prdata[7:0] = st.ctrl | {6'h00, st.stat};
      end else if (paddr == uart_pkg::ADDR_DATA) begin
        next_st.prdata[7:0] = st.rx_buf;
      end else if (paddr == uart_pkg::ADDR_TMR) begin
        next_st.prdata[3:0] = st.tmr;
      end else if (paddr == uart_pkg::ADDR_RELOAD) begin
        next_st.prdata[15:0] = {st.tl, st.reload};
      end else if (paddr == uart_pkg::ADDR_STAT) begin
        next_st.prdata[1:0] = st.stat;
      end else if (paddr == uart_pkg::ADDR_MASK) begin
        next_st.prdata[1:0] = st.mask;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.rx_s1 <= 1'b1;
      st.rx_s2 <= 1'b1;
      st.rx_s3 <= 1'b1;
      st.txd <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign txd = st.txd;
  assign irq = st.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  irq_follows_flags_a: assert property (irq == |(st.stat & st.mask))
    else $error("interrupt does not match enabled flags");
  flag_clear_by_sw_a: assert property ($fell(st.stat[uart_pkg::STAT_RI]) |->
    $past(wr_go && paddr == uart_pkg::ADDR_STAT && pwdata[0]))
    else $error("receive flag cleared without software write");
  write_starts_tx_a: assert property (
    wr_go && paddr == uart_pkg::ADDR_DATA && st.tx_st == uart_pkg::TX_IDLE
    |=> st.tx_st == uart_pkg::TX_WAIT && st.tx_sh[7:0] == $past(pwdata[7:0]))
    else $error("data write did not load the transmitter");
  read_gives_buf_a: assert property (rd_go && paddr == uart_pkg::ADDR_DATA |=>
    pready && prdata == {24'h000000, $past(st.rx_buf)})
    else $error("data read did not return receive buffer");
  timer_reload_a: assert property (tx_ovf |=> st.tl == $past(st.reload))
    else $error("timer did not reload on overflow");
  start_reload_a: assert property (start_det |=>
    st.rx_tl == $past(st.reload) && !st.rx_div && st.rx_st == uart_pkg::RX_START)
    else $error("start edge did not reload receive copy");
  halved_rate_a: assert property (tx_bit |-> ##1 !st.tx_div[*1] ##0 !tx_bit)
    else $error("bit tick not halved");
  tx_flag_stop_a: assert property ($rose(st.stat[uart_pkg::STAT_TI]) |->
    st.tx_st == uart_pkg::TX_STOP && txd)
    else $error("transmit flag not at stop bit start");
  rx_accept_a: assert property ($rose(st.stat[uart_pkg::STAT_RI]) |->
    $past(!st.ctrl[uart_pkg::CTRL_MCE] || st.ctrl[uart_pkg::CTRL_RB8] ||
          (st.rx_st == uart_pkg::RX_STOP)) && st.ctrl[uart_pkg::CTRL_RB8] ||
    !$past(st.ctrl[uart_pkg::CTRL_MCE]))
    else $error("receive accepted against filter");
  tx_done_c: cover property ($rose(st.stat[uart_pkg::STAT_TI]));
  rx_done_c: cover property ($rose(st.stat[uart_pkg::STAT_RI]));
  nine_bit_c: cover property ($rose(st.stat[uart_pkg::STAT_RI]) &&
    st.ctrl[uart_pkg::CTRL_MODE9]);
  false_start_c: cover property (st.rx_st == uart_pkg::RX_START && rx_samp && st.rx_s2);
endmodule : uart_timer_baud
